// >>> inc/brc_pkg.sv
// constants and types shared by the boot remap control ends
package brc_pkg;

	// system_control field positions and reset value (bits 15:11 not held here)
	localparam int unsigned BRC_BMS_LSB       = 0;
	localparam int unsigned BRC_BMS_MSB       = 2;
	localparam int unsigned BRC_VEC_REMAP_BIT = 3;
	localparam int unsigned BRC_DBG_EN_BIT    = 7;
	localparam int unsigned BRC_CRAM_SEL_BIT  = 10;
	localparam logic [15:0] BRC_SYSCTL_RESET  = 16'h0020;
	localparam logic [15:0] BRC_SYSCTL_WMASK  = 16'h07FF;

	// boot memory select codes
	typedef enum logic [2:0] {
		BRC_BMS_ROM     = 3'h0,
		BRC_BMS_IFLASH  = 3'h1,
		BRC_BMS_XFLASH  = 3'h2,
		BRC_BMS_SYSRAM  = 3'h3,
		BRC_BMS_RAM3    = 3'h4,
		BRC_BMS_CRAM    = 3'h5,
		BRC_BMS_XF_UNC  = 3'h6,
		BRC_BMS_UNDEF   = 3'h7
	} brc_bms_t;

	// access sizes
	typedef enum logic [1:0] {
		BRC_SZ_8  = 2'h0,
		BRC_SZ_16 = 2'h1,
		BRC_SZ_32 = 2'h2,
		BRC_SZ_64 = 2'h3
	} brc_size_t;

	// address map
	localparam logic [31:0] BRC_VEC_LAST      = 32'h0000_01FF;
	localparam logic [31:0] BRC_SYSRAM_BASE   = 32'h0080_0000;
	localparam logic [31:0] BRC_ZERO_WIN_MASK = 32'hFFF8_0000;
	localparam logic [31:0] BRC_ROM_BASE      = 32'h0090_0000;
	localparam logic [31:0] BRC_RAM3_BASE     = 32'h0081_0000;
	localparam logic [31:0] BRC_CRAM_BASE     = 32'h0082_0000;
	localparam logic [31:0] BRC_IF_WIN_BASE   = 32'h00A0_0000;
	localparam logic [31:0] BRC_IF_WIN_MASK   = 32'hFFF0_0000;
	localparam logic [31:0] BRC_IF_UNC_BASE   = 32'h3100_0000;
	localparam logic [31:0] BRC_XF_WIN_BASE   = 32'h1600_0000;
	localparam logic [31:0] BRC_XF_UNC_BASE   = 32'h3200_0000;
	localparam logic [31:0] BRC_BIG_WIN_MASK  = 32'hFF00_0000;

	// cache flush geometry
	localparam int unsigned BRC_LINE_W  = 9;
	localparam logic [8:0]  BRC_LINE_LAST = 9'h1FF;

	// controller apb register offsets
	localparam logic [7:0]  BRC_OFS_CMD    = 8'h00;
	localparam logic [7:0]  BRC_OFS_STATUS = 8'h04;
	localparam logic [7:0]  BRC_OFS_ACCESS = 8'h08;
	localparam logic [7:0]  BRC_OFS_ATTR   = 8'h0C;
	localparam logic [7:0]  BRC_OFS_RESULT = 8'h10;

	// controller status bit positions
	localparam int unsigned BRC_ST_FLUSH   = 16;
	localparam int unsigned BRC_ST_REFUSED = 17;
	localparam int unsigned BRC_ST_RSP     = 18;
	localparam int unsigned BRC_ST_CACHED  = 19;
	localparam int unsigned BRC_ST_FAULT   = 20;
	localparam int unsigned BRC_ST_BOOTED  = 21;
	localparam int unsigned BRC_ST_BUSY    = 22;

endpackage : brc_pkg

// >>> inc/brc_if.sv
// link between the remap device and its controlling master
`timescale 1ns/1ps
interface brc_if;
	import brc_pkg::*;
	logic        wr_en;     // write strobe for system_control
	logic [15:0] wr_data;   // value written
	logic [15:0] rd_data;   // current system_control
	logic        flush_busy;// cache flush running
	logic        req_valid; // access request pulse
	logic [31:0] req_addr;  // logical address
	logic [1:0]  req_size;  // access size
	logic        req_dma;   // request comes from dma
	logic        rsp_valid; // translation ready pulse
	logic [31:0] rsp_addr;  // physical address
	logic        rsp_cached;// access goes through cache
	logic        rsp_fault; // access not allowed

	modport dev (input wr_en, wr_data, req_valid, req_addr, req_size, req_dma,
		output rd_data, flush_busy, rsp_valid, rsp_addr, rsp_cached, rsp_fault);
	modport ctl (output wr_en, wr_data, req_valid, req_addr, req_size, req_dma,
		input rd_data, flush_busy, rsp_valid, rsp_addr, rsp_cached, rsp_fault);
endinterface : brc_if

// >>> hw/brc_remap_dev.sv
// boot address remap device: system_control bits 10:0, cache flush, address translation
`timescale 1ns/1ps

module brc_remap_dev
	import brc_pkg::*;
(
	input  wire logic        i_clk_sys,     // system clock 10 MHz
	input  wire logic        i_reset_n,     // async reset, active low
	brc_if.dev               bus,           // link to the master
	input  wire logic [31:0] i_if_base,     // internal external_a
	input  wire logic [11:0] i_if_offset,   // internal flash region offset, words
	input  wire logic [31:0] i_if_size,     // internal flash region size, bytes
	input  wire logic [31:0] i_xf_base,     // external external_a
	input  wire logic [11:0] i_xf_offset,   // external flash region offset, words
	input  wire logic [31:0] i_xf_size,     // external flash region size, bytes
	output logic             o_dbg_en,      // debug port enabled
	output logic             o_dbg_pins_gpio, // debug pins free for gpio
	output logic             o_cache_ctl_en,  // cache controller active
	output logic             o_cram_visible,  // cache ram in memory map
	output logic             o_clr_valid,   // zero-write strobe to cache line
	output logic [8:0]       o_clr_line     // cache line being zeroed
);

	typedef enum logic [1:0] {
		BRC_FL_IDLE = 2'b01,
		BRC_FL_RUN  = 2'b10
	} brc_fl_t;

	logic [10:0] ctl_r;
	logic [10:0] ctl_nxt;
	brc_fl_t     fl_r;
	brc_fl_t     fl_nxt;
	logic [8:0]  line_r;
	logic [8:0]  line_nxt;
	logic        rsp_v_r;
	logic        rsp_v_nxt;
	logic [31:0] rsp_a_r;
	logic [31:0] rsp_a_nxt;
	logic        rsp_c_r;
	logic        rsp_c_nxt;
	logic        rsp_f_r;
	logic        rsp_f_nxt;
	logic        cram_sel;
	brc_bms_t    bms;

	assign cram_sel = ctl_r[BRC_CRAM_SEL_BIT];
	assign bms      = brc_bms_t'(ctl_r[BRC_BMS_MSB:BRC_BMS_LSB]);

	// byte offset of a region from its word offset field
	function automatic logic [31:0] brc_ofs4(input logic [11:0] ofs);
		brc_ofs4 = {18'h0, ofs, 2'b00};
	endfunction : brc_ofs4

	////////////////////////////////////////////////////////////////////////
	// register and flush sequencing
	always_comb begin
		ctl_nxt  = ctl_r;
		fl_nxt   = fl_r;
		line_nxt = line_r;
		if (bus.wr_en) begin
			ctl_nxt = bus.wr_data[10:0] & BRC_SYSCTL_WMASK[10:0];
		end
		unique case (fl_r)
			BRC_FL_IDLE: begin
				// falling cache select restarts the reset-time flush
				if (bus.wr_en && cram_sel && !bus.wr_data[BRC_CRAM_SEL_BIT]) begin
					fl_nxt   = BRC_FL_RUN;
					line_nxt = '0;
				end
			end
			BRC_FL_RUN: begin
				line_nxt = line_r + 9'h001;
				if (line_r == BRC_LINE_LAST) begin
					fl_nxt   = BRC_FL_IDLE;
					line_nxt = '0;
				end
			end
		endcase
	end

	// state registers; flush runs right after reset
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctl_r  <= BRC_SYSCTL_RESET[10:0];
			fl_r   <= BRC_FL_RUN;
			line_r <= '0;
		end else begin
			ctl_r  <= ctl_nxt;
			fl_r   <= fl_nxt;
			line_r <= line_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address translation, answered one cycle after the request
	always_comb begin
		logic [31:0] a;
		logic [31:0] rel;
		a         = bus.req_addr;
		rel       = '0;
		rsp_v_nxt = bus.req_valid;
		rsp_a_nxt = rsp_a_r;
		rsp_c_nxt = rsp_c_r;
		rsp_f_nxt = rsp_f_r;
		if (bus.req_valid) begin
			rsp_a_nxt = a;
			rsp_c_nxt = 1'b0;
			rsp_f_nxt = 1'b0;
			if (ctl_r[BRC_VEC_REMAP_BIT] && a <= BRC_VEC_LAST) begin
				rsp_a_nxt = BRC_SYSRAM_BASE + a;
			end else if ((a & BRC_ZERO_WIN_MASK) == 32'h0000_0000) begin
				unique case (bms)
					BRC_BMS_IFLASH: begin
						rsp_a_nxt = i_if_base + brc_ofs4(i_if_offset) + a;
						rsp_c_nxt = 1'b1;
						rsp_f_nxt = (a >= i_if_size);
					end
					BRC_BMS_XFLASH: begin
						rsp_a_nxt = i_xf_base + brc_ofs4(i_xf_offset) + a;
						rsp_c_nxt = 1'b1;
						rsp_f_nxt = (a >= i_xf_size);
					end
					BRC_BMS_SYSRAM: rsp_a_nxt = BRC_SYSRAM_BASE + a;
					BRC_BMS_RAM3:   rsp_a_nxt = BRC_RAM3_BASE + a;
					BRC_BMS_CRAM: begin
						rsp_a_nxt = BRC_CRAM_BASE + a;
						// misuse that software must avoid is reported, not served
						rsp_f_nxt = cram_sel || bus.req_dma
							|| (bus.req_size == BRC_SZ_64);
					end
					BRC_BMS_XF_UNC: rsp_a_nxt = BRC_XF_UNC_BASE + a;
					BRC_BMS_ROM,
					BRC_BMS_UNDEF:  rsp_a_nxt = BRC_ROM_BASE + a;
				endcase
			end else if ((a & BRC_IF_WIN_MASK) == BRC_IF_WIN_BASE) begin
				// configured internal flash region only through its window
				rel       = a - BRC_IF_WIN_BASE;
				rsp_a_nxt = i_if_base + brc_ofs4(i_if_offset) + rel;
				rsp_c_nxt = 1'b1;
				rsp_f_nxt = (rel >= i_if_size);
			end else if ((a & BRC_BIG_WIN_MASK) == BRC_XF_WIN_BASE) begin
				rel       = a - BRC_XF_WIN_BASE;
				rsp_a_nxt = i_xf_base + brc_ofs4(i_xf_offset) + rel;
				rsp_c_nxt = 1'b1;
				rsp_f_nxt = (rel >= i_xf_size);
			end else if ((a & BRC_BIG_WIN_MASK) == BRC_IF_UNC_BASE
				|| (a & BRC_BIG_WIN_MASK) == BRC_XF_UNC_BASE) begin
				rsp_a_nxt = a; // whole flash, uncached
			end else if ((a & BRC_ZERO_WIN_MASK) == BRC_SYSRAM_BASE && a >= BRC_CRAM_BASE) begin
				// cache ram hidden while the controller owns it
				rsp_f_nxt = cram_sel;
			end
		end
	end

	// translation result registers
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rsp_v_r <= 1'b0;
			rsp_a_r <= '0;
			rsp_c_r <= 1'b0;
			rsp_f_r <= 1'b0;
		end else begin
			rsp_v_r <= rsp_v_nxt;
			rsp_a_r <= rsp_a_nxt;
			rsp_c_r <= rsp_c_nxt;
			rsp_f_r <= rsp_f_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign bus.rd_data    = {5'h00, ctl_r};
	assign bus.flush_busy = (fl_r == BRC_FL_RUN);
	assign bus.rsp_valid  = rsp_v_r;
	assign bus.rsp_addr   = rsp_a_r;
	assign bus.rsp_cached = rsp_c_r;
	assign bus.rsp_fault  = rsp_f_r;

	// debug pins go to gpio while the enable is clear
	assign o_dbg_en        = ctl_r[BRC_DBG_EN_BIT];
	assign o_dbg_pins_gpio = !ctl_r[BRC_DBG_EN_BIT];
	// controller held off during flush; cache ram shown only when bypassed
	assign o_cache_ctl_en  = cram_sel && (fl_r == BRC_FL_IDLE);
	assign o_cram_visible  = !cram_sel;
	assign o_clr_valid     = (fl_r == BRC_FL_RUN);
	assign o_clr_line      = line_r;

endmodule : brc_remap_dev

// >>> hw/brc_remap_ctl.sv
// remap controller: apb slave that boots and drives the remap device
`timescale 1ns/1ps
module brc_remap_ctl
	import brc_pkg::*;
(
	input  wire logic        i_clk_sys,  // system clock 10 MHz
	input  wire logic        i_reset_n,  // async reset, active low
	brc_if.ctl               dev,        // link to the remap device
	input  wire logic        i_otp_dbg,  // otp debug setting, asynchronous
	input  wire logic        psel,       // apb select
	input  wire logic        penable,    // apb enable
	input  wire logic        pwrite,     // apb direction
	input  wire logic [31:0] paddr,      // apb address
	input  wire logic [31:0] pwdata,     // apb write data
	output logic             pready,     // apb ready
	output logic [31:0]      prdata,     // apb read data
	output logic             pslverr     // apb error
);

	typedef enum logic [3:0] {
		BRC_CS_SYNC   = 4'b0001,
		BRC_CS_SETTLE = 4'b0010,
		BRC_CS_BOOT   = 4'b0100,
		BRC_CS_RUN    = 4'b1000
	} brc_cs_t;

	brc_cs_t     st_r;
	brc_cs_t     st_nxt;
	logic [1:0]  otp_sync_r;
	logic        wr_en_r;
	logic        wr_en_nxt;
	logic [15:0] wr_d_r;
	logic [15:0] wr_d_nxt;
	logic        req_r;
	logic        req_nxt;
	logic [31:0] acc_r;
	logic [31:0] acc_nxt;
	logic [2:0]  attr_r;
	logic [2:0]  attr_nxt;
	logic [31:0] res_r;
	logic [31:0] res_nxt;
	logic [4:0]  flg_r;
	logic [4:0]  flg_nxt;
	logic        wr_acc;

	assign wr_acc = psel && penable && pwrite;

	////////////////////////////////////////////////////////////////////////
	// otp setting crosses two flops before use
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			otp_sync_r <= 2'b00;
		end else begin
			otp_sync_r <= {otp_sync_r[0], i_otp_dbg};
		end
	end

	// boot sequence and software commands
	always_comb begin
		logic [15:0] cmd;
		logic [2:0]  code;
		cmd       = pwdata[15:0];
		code      = pwdata[BRC_BMS_MSB:BRC_BMS_LSB];
		st_nxt    = st_r;
		wr_en_nxt = 1'b0;
		wr_d_nxt  = wr_d_r;
		req_nxt   = 1'b0;
		acc_nxt   = acc_r;
		attr_nxt  = attr_r;
		res_nxt   = res_r;
		flg_nxt   = flg_r;
		// answer first, so a request taken in the same cycle keeps its pending flag
		if (dev.rsp_valid) begin
			res_nxt    = dev.rsp_addr;
			flg_nxt[0] = 1'b0;
			flg_nxt[2] = 1'b1;
			flg_nxt[3] = dev.rsp_cached;
			flg_nxt[4] = dev.rsp_fault;
		end
		unique case (st_r)
			BRC_CS_SYNC: st_nxt = BRC_CS_SETTLE;
			// otp level is valid only once both sync flops hold it
			BRC_CS_SETTLE: st_nxt = BRC_CS_BOOT;
			BRC_CS_BOOT: begin
				// copy the otp debug setting into the debug enable bit
				wr_en_nxt = 1'b1;
				wr_d_nxt  = dev.rd_data;
				wr_d_nxt[BRC_DBG_EN_BIT] = otp_sync_r[1];
				st_nxt    = BRC_CS_RUN;
			end
			BRC_CS_RUN: begin
				if (wr_acc && paddr[7:0] == BRC_OFS_CMD) begin
					// undefined code, or cram with the cache select bit set in the same command
					if (code == BRC_BMS_UNDEF
						|| (code == BRC_BMS_CRAM && cmd[BRC_CRAM_SEL_BIT])) begin
						flg_nxt[1] = 1'b1;
					end else begin
						wr_en_nxt = 1'b1;
						wr_d_nxt  = cmd;
						flg_nxt[1] = 1'b0;
					end
				end
				if (wr_acc && paddr[7:0] == BRC_OFS_ATTR) begin
					attr_nxt = pwdata[2:0];
				end
				if (wr_acc && paddr[7:0] == BRC_OFS_ACCESS) begin
					acc_nxt = pwdata;
					// 64-bit or dma accesses are not issued while cram is the boot memory code
					if (dev.rd_data[BRC_BMS_MSB:BRC_BMS_LSB] == BRC_BMS_CRAM
						&& (attr_r[2] || attr_r[1:0] == BRC_SZ_64)) begin
						flg_nxt[1] = 1'b1;
					end else begin
						req_nxt    = 1'b1;
						flg_nxt[0] = 1'b1;
						flg_nxt[2] = 1'b0;
					end
				end
			end
			default: st_nxt = BRC_CS_SYNC;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r    <= BRC_CS_SYNC;
			wr_en_r <= 1'b0;
			wr_d_r  <= '0;
			req_r   <= 1'b0;
			acc_r   <= '0;
			attr_r  <= '0;
			res_r   <= '0;
			flg_r   <= '0;
		end else begin
			st_r    <= st_nxt;
			wr_en_r <= wr_en_nxt;
			wr_d_r  <= wr_d_nxt;
			req_r   <= req_nxt;
			acc_r   <= acc_nxt;
			attr_r  <= attr_nxt;
			res_r   <= res_nxt;
			flg_r   <= flg_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// device link and apb read mux
	assign dev.wr_en     = wr_en_r;
	assign dev.wr_data   = wr_d_r;
	assign dev.req_valid = req_r;
	assign dev.req_addr  = acc_r;
	assign dev.req_size  = attr_r[1:0];
	assign dev.req_dma   = attr_r[2];
	assign pready        = 1'b1;

	always_comb begin
		prdata  = '0;
		pslverr = 1'b0;
		unique case (paddr[7:0])
			BRC_OFS_CMD:    prdata = {16'h0000, dev.rd_data};
			BRC_OFS_STATUS: prdata = {9'h000, (wr_en_r | req_r | flg_r[0]),
				(st_r == BRC_CS_RUN), flg_r[4], flg_r[3], flg_r[2], flg_r[1],
				dev.flush_busy, dev.rd_data};
			BRC_OFS_ACCESS: prdata = acc_r;
			BRC_OFS_ATTR:   prdata = {29'h0, attr_r};
			BRC_OFS_RESULT: prdata = res_r;
			default:        pslverr = psel && penable;
		endcase
	end

endmodule : brc_remap_ctl

// >>> testbench/brc_link_monitor.sv
// link monitor: concurrent checks on the signals between the two remap ends
`timescale 1ns/1ps
module brc_link_monitor
	import brc_pkg::*;
(
	input wire logic        i_clk_sys,  // system clock
	input wire logic        i_reset_n,  // async reset, active low
	input wire logic        wr_en,      // load strobe
	input wire logic [15:0] wr_data,    // value loaded
	input wire logic [15:0] rd_data,    // system_control
	input wire logic        flush_busy, // flush running
	input wire logic        req_valid,  // request pulse
	input wire logic [31:0] req_addr,   // logical address
	input wire logic [1:0]  req_size,   // access size
	input wire logic        req_dma,    // dma request
	input wire logic        rsp_valid,  // answer pulse
	input wire logic [31:0] rsp_addr,   // physical address
	input wire logic        rsp_cached, // cached access
	input wire logic        rsp_fault   // refused access
);
	logic [9:0] busy_cnt_r;
	logic [9:0] busy_cnt_nxt;
	logic       zero_win;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);

	////////////////////////////////////////////////////////////////////////////////
	// length of the current flush run
	always_comb begin
		busy_cnt_nxt = flush_busy ? busy_cnt_r + 10'h001 : 10'h000;
	end
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy_cnt_r <= 10'h000;
		end else begin
			busy_cnt_r <= busy_cnt_nxt;
		end
	end
	// request that hits the address zero alias, vector remap excluded
	assign zero_win = req_valid && !(rd_data[3] && req_addr <= BRC_VEC_LAST)
		&& (req_addr & BRC_ZERO_WIN_MASK) == 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	chk_vec_remap: assert property (
		req_valid && rd_data[3] && req_addr <= BRC_VEC_LAST |=> rsp_valid
		&& rsp_addr == $past(req_addr) + BRC_SYSRAM_BASE && !rsp_cached)
		else $error("vector remap address wrong");
	chk_rom_zero: assert property (
		zero_win && (rd_data[2:0] == 3'h0 || rd_data[2:0] == 3'h7)
		|=> rsp_valid && rsp_addr == $past(req_addr) + BRC_ROM_BASE && !rsp_cached)
		else $error("rom alias wrong");
	chk_ram3_zero: assert property (
		zero_win && rd_data[2:0] == 3'h4 |=> rsp_addr == $past(req_addr) + BRC_RAM3_BASE)
		else $error("third ram alias wrong");
	chk_cram_zero: assert property (
		zero_win && rd_data[2:0] == 3'h5 && !rd_data[10] && !req_dma && req_size != 2'h3
		|=> rsp_addr == $past(req_addr) + BRC_CRAM_BASE && !rsp_fault && !rsp_cached)
		else $error("cache ram alias wrong");
	chk_xf_uncached: assert property (
		zero_win && rd_data[2:0] == 3'h6
		|=> rsp_addr == $past(req_addr) + BRC_XF_UNC_BASE && !rsp_cached)
		else $error("uncached flash alias wrong");
	chk_wr_load: assert property (
		wr_en |=> rd_data == ($past(wr_data) & BRC_SYSCTL_WMASK))
		else $error("system_control load wrong");
	chk_rd_upper: assert property (rd_data[15:11] == 5'h00)
		else $error("upper bits not zero");
	chk_flush_start: assert property ($fell(rd_data[10]) |-> ##[0:1] flush_busy)
		else $error("flush not started");
	chk_flush_len: assert property ($fell(flush_busy) |-> busy_cnt_r == 10'h200)
		else $error("flush length wrong");
endmodule : brc_link_monitor

// >>> testbench/test_boot_address_remap_control.sv
// bench: both remap ends joined over the link, controller driven over apb
`timescale 1ns/1ps
module test_boot_address_remap_control;
	import brc_pkg::*;
	logic        i_clk_sys;
	logic        i_reset_n;
	logic        i_otp_dbg;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        pready;
	logic        pslverr;
	logic        rerr;
	logic        dbg_en;
	logic        pins_gpio;
	logic        ctl_en;
	logic        cram_vis;
	logic        clr_valid;
	logic [8:0]  clr_line;
	logic [11:0] if_off;
	logic [11:0] xf_off;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] if_base;
	logic [31:0] if_size;
	logic [31:0] xf_base;
	logic [31:0] xf_size;
	logic [31:0] rdat;
	logic [31:0] seed;
	logic [31:0] a;
	int          errors;
	int          checks;
	int          cycles;
	int          n;
	int          bad;

	brc_if lnk ();
	brc_if lnk2 ();

	////////////////////////////////////////////////////////////////////////////////
	// the two ends, a rogue-driven second device, and the link monitor
	brc_remap_dev i_brc_remap_dev (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .bus(lnk),
		.i_if_base(if_base), .i_if_offset(if_off), .i_if_size(if_size), .i_xf_base(xf_base),
		.i_xf_offset(xf_off), .i_xf_size(xf_size), .o_dbg_en(dbg_en),
		.o_dbg_pins_gpio(pins_gpio), .o_cache_ctl_en(ctl_en), .o_cram_visible(cram_vis),
		.o_clr_valid(clr_valid), .o_clr_line(clr_line));
	brc_remap_dev i_brc_remap_dev_rogue (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
		.bus(lnk2), .i_if_base(if_base), .i_if_offset(if_off), .i_if_size(if_size),
		.i_xf_base(xf_base), .i_xf_offset(xf_off), .i_xf_size(xf_size), .o_dbg_en(),
		.o_dbg_pins_gpio(), .o_cache_ctl_en(), .o_cram_visible(), .o_clr_valid(),
		.o_clr_line());
	brc_remap_ctl i_brc_remap_ctl (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .dev(lnk),
		.i_otp_dbg(i_otp_dbg), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
	brc_link_monitor i_brc_link_monitor (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
		.wr_en(lnk.wr_en), .wr_data(lnk.wr_data), .rd_data(lnk.rd_data),
		.flush_busy(lnk.flush_busy), .req_valid(lnk.req_valid), .req_addr(lnk.req_addr),
		.req_size(lnk.req_size), .req_dma(lnk.req_dma), .rsp_valid(lnk.rsp_valid),
		.rsp_addr(lnk.rsp_addr), .rsp_cached(lnk.rsp_cached), .rsp_fault(lnk.rsp_fault));

	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial i_clk_sys = 1'b0;
	always #50 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		cycles = cycles + 1;
		if (cycles == 6000) begin
			errors = errors + 1;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// expected {cached, fault, address} for a zero-window access per code
	function automatic logic [33:0] exp_map(input logic [2:0] c, input logic [31:0] x);
		case (c)
			3'h1: return {1'b1, x >= if_size, if_base + 32'({if_off, 2'b00}) + x};
			3'h2: return {1'b1, x >= xf_size, xf_base + 32'({xf_off, 2'b00}) + x};
			3'h3: return {2'b00, BRC_SYSRAM_BASE + x};
			3'h4: return {2'b00, BRC_RAM3_BASE + x};
			3'h5: return {2'b00, BRC_CRAM_BASE + x};
			3'h6: return {2'b00, BRC_XF_UNC_BASE + x};
			default: return {2'b00, BRC_ROM_BASE + x};
		endcase
	endfunction : exp_map

	task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		checks = checks + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one apb transfer; read data and error land in rdat and rerr
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge i_clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {24'h000000, ad};
		pwdata <= d;
		@(posedge i_clk_sys);
		penable <= 1'b1;
		@(posedge i_clk_sys);
		while (pready !== 1'b1) @(posedge i_clk_sys);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task cmd(input logic [15:0] v);
		apb(1'b1, BRC_OFS_CMD, {16'h0000, v});
	endtask : cmd

	task refused(input logic e);
		apb(1'b0, BRC_OFS_STATUS, 32'h0000_0000);
		chk("refused flag", 34'(e), 34'(rdat[BRC_ST_REFUSED]));
	endtask : refused

	// translate one address through the controller and compare the result
	task access(input logic [31:0] x, input logic [31:0] at, input logic [33:0] e);
		logic [33:0] g;
		apb(1'b1, BRC_OFS_ATTR, at);
		apb(1'b1, BRC_OFS_ACCESS, x);
		repeat (2) @(posedge i_clk_sys);
		apb(1'b0, BRC_OFS_STATUS, 32'h0000_0000);
		g[33:32] = {rdat[BRC_ST_CACHED], rdat[BRC_ST_FAULT]};
		chk("status", 34'h3,
			34'({rdat[BRC_ST_BUSY], rdat[BRC_ST_BOOTED], rdat[BRC_ST_RSP]}));
		apb(1'b0, BRC_OFS_RESULT, 32'h0000_0000);
		g[31:0] = rdat;
		chk("translation", e, g);
	endtask : access

	// load the rogue device directly, then translate address a on it
	task raw(input logic [15:0] wd, input logic [2:0] at, input logic [33:0] e);
		@(posedge i_clk_sys);
		lnk2.wr_en <= 1'b1;
		lnk2.wr_data <= wd;
		@(posedge i_clk_sys);
		lnk2.wr_en <= 1'b0;
		lnk2.req_valid <= 1'b1;
		lnk2.req_addr <= a;
		lnk2.req_dma <= at[2];
		lnk2.req_size <= at[1:0];
		@(posedge i_clk_sys);
		lnk2.req_valid <= 1'b0;
		@(posedge i_clk_sys);
		chk("rogue access", e, {lnk2.rsp_cached, lnk2.rsp_fault, lnk2.rsp_addr});
	endtask : raw

	task finish_test();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		errors = 0;
		checks = 0;
		cycles = 0;
		seed = 32'h0000_1883;
		if_base = rnd() & 32'h00FF_FFFC;
		rdat = rnd();
		if_off = rdat[11:0];
		if_size = rnd() & 32'h0007_FFFF;
		xf_base = rnd() & 32'h0FFF_FFFC;
		rdat = rnd();
		xf_off = rdat[11:0];
		xf_size = 32'h0004_0000;
		i_reset_n = 1'b0;
		i_otp_dbg = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		lnk2.wr_en = 1'b0;
		lnk2.wr_data = 16'h0000;
		lnk2.req_valid = 1'b0;
		lnk2.req_addr = 32'h0000_0000;
		lnk2.req_size = 2'h2;
		lnk2.req_dma = 1'b0;
		repeat (5) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		repeat (600) @(posedge i_clk_sys);
		apb(1'b0, BRC_OFS_CMD, 32'h0000_0000);
		chk("boot value", 34'h0_0000_00A0, {2'b00, rdat});
		chk("debug pins", 34'h2, 34'({dbg_en, pins_gpio}));
		cmd(16'h0400);
		repeat (3) @(posedge i_clk_sys);
		chk("cache on", 34'h9, 34'({ctl_en, cram_vis, dbg_en, pins_gpio}));
		access(BRC_CRAM_BASE, 32'h2, {2'b01, BRC_CRAM_BASE});
		cmd(16'h0000);
		n = 0;
		bad = 0;
		repeat (700) begin
			@(posedge i_clk_sys);
			if (clr_valid === 1'b1) begin
				if (clr_line !== n[8:0]) bad = bad + 1;
				n = n + 1;
			end
		end
		chk("flush lines", 34'h200, 34'(n));
		chk("flush order", 34'h0, 34'(bad));
		chk("cache off", 34'h5, 34'({ctl_en, cram_vis, dbg_en, pins_gpio}));
		access(BRC_CRAM_BASE, 32'h2, {2'b00, BRC_CRAM_BASE});
		// boot memory codes 0 to 6 at a random zero-window address; code 7 is refused and code 6 stays
		for (int c = 0; c < 8; c++) begin
			cmd(16'(c));
			refused(c == 7);
			rdat = rnd();
			a = rdat & 32'h0007_FFFC;
			access(a, 32'h2, exp_map((c == 7) ? 3'h6 : 3'(c), a));
		end
		cmd(16'h000A);
		rdat = rnd();
		a = rdat & 32'h0000_01FC;
		access(a, 32'h2, {2'b00, BRC_SYSRAM_BASE + a});
		access(32'h0000_0200, 32'h2, exp_map(3'h2, 32'h0000_0200));
		cmd(16'h0002);
		access(a, 32'h2, exp_map(3'h2, a));
		rdat = rnd();
		a = rdat & 32'h0003_FFFC;
		access(32'h1600_0000 + a, 32'h2, exp_map(3'h2, a));
		access(32'h3200_0000 + a, 32'h2, {2'b00, 32'h3200_0000 + a});
		cmd(16'h0001);
		access(32'h00A0_0000 + a, 32'h2, exp_map(3'h1, a));
		access(32'h3100_0000 + a, 32'h2, {2'b00, 32'h3100_0000 + a});
		// refusals by the controller
		cmd(16'h0405);
		refused(1'b1);
		cmd(16'h0005);
		refused(1'b0);
		apb(1'b1, BRC_OFS_ATTR, 32'h6);
		apb(1'b1, BRC_OFS_ACCESS, a);
		refused(1'b1);
		cmd(16'h0005);
		apb(1'b1, BRC_OFS_ATTR, 32'h3);
		apb(1'b1, BRC_OFS_ACCESS, a);
		refused(1'b1);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk("unmapped error", 34'h1, 34'(rerr));
		// second reset with the otp debug setting cleared
		i_otp_dbg <= 1'b0;
		i_reset_n <= 1'b0;
		repeat (5) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		repeat (600) @(posedge i_clk_sys);
		apb(1'b0, BRC_OFS_CMD, 32'h0000_0000);
		chk("boot value", 34'h0_0000_0020, {2'b00, rdat});
		chk("debug pins", 34'h1, 34'({dbg_en, pins_gpio}));
		// rogue master breaks the rules on the second link
		rdat = rnd();
		a = rdat & 32'h0007_FFFC;
		raw(16'h0405, 3'h2, {2'b01, BRC_CRAM_BASE + a});
		raw(16'h0005, 3'h6, {2'b01, BRC_CRAM_BASE + a});
		raw(16'h0005, 3'h3, {2'b01, BRC_CRAM_BASE + a});
		raw(16'h0005, 3'h2, {2'b00, BRC_CRAM_BASE + a});
		raw(16'h0007, 3'h2, {2'b00, BRC_ROM_BASE + a});
		finish_test();
	end
endmodule : test_boot_address_remap_control
